// ### verilog/pm_pkg.sv
package pm_pkg;

  // ==========================================================
  // timing
  localparam int unsigned REF_CLK_HZ = 25_000_000;
  localparam int unsigned T_TIMEOUT_MS = 25;
  localparam int unsigned TIMEOUT_CYC = T_TIMEOUT_MS * (REF_CLK_HZ / 1000);
  localparam int unsigned LOW_CNT_W = 20;

  // ==========================================================
  // bus constants
  localparam logic [6:0] ARA_ADDR = 7'h0c;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [7:0] IDLE_BYTE = 8'hff;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [2:0] LEN_BAD = 3'h7;

  // ==========================================================
  // command codes
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_STORE_USER_ALL = 8'h15;
  localparam logic [7:0] CMD_VOUT_MODE = 8'h20;
  localparam logic [7:0] CMD_VOUT_COMMAND = 8'h21;
  localparam logic [7:0] CMD_IOUT_OC_FAULT_LIMIT = 8'h46;
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;

  // ==========================================================
  // number formats and defaults
  localparam logic [2:0] MODE_LINEAR = 3'h0;
  localparam logic [4:0] VOUT_EXP = 5'h17;
  localparam logic [7:0] VOUT_MODE_VAL = {MODE_LINEAR, VOUT_EXP};
  localparam logic [4:0] OC_EXP = 5'h1f;
  localparam int unsigned OC_EXP_HI = 7;
  localparam int unsigned OC_EXP_LO = 3;
  localparam logic [15:0] VOUT_DEF = 16'h0133;
  localparam logic [15:0] OC_DEF = {OC_EXP, 11'h028};
  localparam int unsigned STS_CML_BIT = 1;
  localparam int unsigned STS_NONE_BIT = 0;

  typedef enum logic [2:0] {
    ph_idle, ph_addr, ph_cmd, ph_data, ph_read, ph_ignore
  } pm_phase_e;

  function automatic logic [7:0] pm_crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] x;
    x = c ^ b;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? ((x << 1) ^ CRC_POLY) : (x << 1);
    end
    return x;
  endfunction

  function automatic logic [2:0] pm_wr_len(input logic [7:0] cmd);
    case (cmd)
      CMD_CLEAR_FAULTS, CMD_STORE_USER_ALL: return 3'h0;
      CMD_VOUT_COMMAND, CMD_IOUT_OC_FAULT_LIMIT: return 3'h2;
      default: return LEN_BAD;
    endcase
  endfunction

  function automatic logic [2:0] pm_rd_len(input logic [7:0] cmd);
    case (cmd)
      CMD_VOUT_MODE, CMD_STATUS_BYTE: return 3'h1;
      CMD_VOUT_COMMAND, CMD_IOUT_OC_FAULT_LIMIT: return 3'h2;
      default: return LEN_BAD;
    endcase
  endfunction

endpackage

// ### verilog/pm_sync2.sv
`timescale 1ns/1ps
module pm_sync2 #(
  parameter int unsigned W = 1
) (
  input wire logic clk, // sampling clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [W-1:0] d, // asynchronous inputs
  output logic [W-1:0] q // synchronised outputs
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pm_sync_s;

  pm_sync_s st_q, st_d;

  always_comb begin
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;
endmodule

// ### verilog/pm_link_capture.sv
`timescale 1ns/1ps
module pm_link_capture (
  input wire logic bus_clk, // serial clock from the master
  input wire logic sda_in, // data line level
  output logic bit_q, // data bit taken at the last rising edge
  output logic tog_q // flips at every rising edge
);
  typedef struct packed {
    logic bit_v;
    logic tog;
  } pm_link_s;

  pm_link_s st_q, st_d;

  // no reset here: this clock only runs during frames. the if-form
  // settles an unknown toggle to one on the first edge, which the
  // core side (reset to zero) then sees as an event
  always_comb begin
    st_d.bit_v = sda_in;
    if (st_q.tog) begin
      st_d.tog = 1'b0;
    end else begin
      st_d.tog = 1'b1;
    end
  end

  always_ff @(posedge bus_clk) begin
    st_q <= st_d;
  end

  assign bit_q = st_q.bit_v;
  assign tog_q = st_q.tog;
endmodule

// ### verilog/pm_slave_core.sv
`timescale 1ns/1ps
// Summary of operation
// R1: slave only, serial clock from 10 kHz to 400 kHz, both timing classes.
// R2: never hold the clock line low; only the data line is ever driven.
// R3: the master keeps its total clock-low extension per message within 10 ms.
// R4: check byte used only when clocked; stop before it means no checking.
// R5: data values use linear format with a fixed exponent; exponent changes refused.
// R6: direct number format is never accepted nor produced.
// R7: only a small subset of management commands is implemented.
// R8: drive the open-drain alert line when a condition needs reporting.
// R9: acknowledge the alert response address only while our alert is pending.
// R10: in the alert response read, return our own slave address.
// R11: master then reads status commands to learn the alert cause.
// R12: settings stay volatile; never committed to the store by ourselves.
// R13: store-all command commits every current setting as power-up default.
// R14: clock held low beyond the bus timeout abandons the transfer.
// R15: unknown command is a communication fault: data refused, status and alert.
module pm_slave_core #(
  parameter int unsigned TIMEOUT_CYCLES = pm_pkg::TIMEOUT_CYC
) (
  input wire logic ref_clk, // core clock, 25 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic bus_clk, // serial clock pin used as link clock
  input wire logic scl_in, // serial clock pin level
  input wire logic sda_in, // serial data pin level
  output logic sda_out, // data pin output value, always low
  output logic sda_oe, // data pin pulled low while high
  output logic alert_request_line_out, // alert pin output value, always low
  output logic alert_request_line_oe, // alert pin pulled low while high
  input wire logic [6:0] own_addr, // slave address strap pins
  input wire logic ext_fault, // regulator fault level, core clock domain
  output logic [15:0] vout_command, // output voltage setting, linear
  output logic [15:0] oc_fault_limit, // overcurrent limit, linear
  output logic nvm_store_pulse, // one-cycle commit request to the store
  output logic comm_fault // communication fault status bit
);
  import pm_pkg::*;

  localparam int unsigned SYNC_W = 11;
  localparam logic [LOW_CNT_W-1:0] TMO = LOW_CNT_W'(TIMEOUT_CYCLES);

  // ==========================================================
  // state
  typedef struct packed {
    pm_phase_e ph;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic ack;
    logic ara;
    logic [7:0] cmd;
    logic bad;
    logic [2:0] widx;
    logic [3:0][7:0] wbuf;
    logic [2:0] ridx;
    logic [7:0] crc;
    logic [7:0] crc_prev;
    logic busy;
    logic oe;
    logic scl_p;
    logic sda_p;
    logic tog_p;
    logic ev;
    logic [LOW_CNT_W-1:0] low_cnt;
    logic [15:0] vout;
    logic [15:0] oclim;
    logic cml;
    logic alert;
    logic fault_p;
    logic nvm_pulse;
  } pm_core_s;

  pm_core_s q, d;

  logic bit_link;
  logic tog_link;
  logic [SYNC_W-1:0] sync_q;
  logic scl_s;
  logic sda_s;
  logic bit_s;
  logic tog_s;
  logic [6:0] addr_s;
  logic start_c;
  logic stop_c;
  logic fall_c;
  logic [7:0] byte_in;
  logic [7:0] status_c;
  logic [7:0] rd_c;
  logic [2:0] wlen_c;
  logic [2:0] rlen_c;
  logic [2:0] ld_idx;
  logic wr_ok;
  logic cml_set;

  // ==========================================================
  // link side and crossings
  pm_link_capture u_link (
    .bus_clk(bus_clk),
    .sda_in(sda_in),
    .bit_q(bit_link),
    .tog_q(tog_link)
  );

  // 40 ns sampling leaves many samples per bit even at 400 kHz [R1]
  pm_sync2 #(.W(SYNC_W)) u_sync (
    .clk(ref_clk),
    .rst(rst),
    .d({own_addr, tog_link, bit_link, sda_in, scl_in}),
    .q(sync_q)
  );

  assign {addr_s, tog_s, bit_s, sda_s, scl_s} = sync_q;
  assign start_c = q.scl_p & scl_s & q.sda_p & ~sda_s;
  assign stop_c = q.scl_p & scl_s & ~q.sda_p & sda_s;
  assign fall_c = q.scl_p & ~scl_s;
  assign byte_in = {q.sh[6:0], bit_s};

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    d.nvm_pulse = 1'b0;
    d.scl_p = scl_s;
    d.sda_p = sda_s;
    d.ev = 1'b0;
    status_c = 8'h00;
    status_c[STS_CML_BIT] = q.cml;
    status_c[STS_NONE_BIT] = ext_fault;
    wlen_c = pm_wr_len(q.cmd);
    rlen_c = pm_rd_len(q.cmd);
    wr_ok = 1'b0;
    cml_set = 1'b0;

    // the bit level settles one cycle after the toggle is seen
    if (tog_s != q.tog_p) begin
      d.tog_p = tog_s;
      d.ev = 1'b1;
    end

    // byte offered for the next read slot
    ld_idx = (q.ph == ph_addr) ? 3'h0 : (q.ridx + 3'h1);
    rd_c = IDLE_BYTE;
    if (ld_idx == rlen_c) begin
      rd_c = q.crc; // [R4]
    end else if (ld_idx < rlen_c) begin
      case (q.cmd)
        CMD_VOUT_MODE: rd_c = VOUT_MODE_VAL; // [R5] [R6]
        CMD_VOUT_COMMAND: rd_c = (ld_idx == 3'h0) ? q.vout[7:0] : q.vout[15:8];
        CMD_IOUT_OC_FAULT_LIMIT: rd_c = (ld_idx == 3'h0) ? q.oclim[7:0] : q.oclim[15:8];
        CMD_STATUS_BYTE: rd_c = status_c;
        default: rd_c = IDLE_BYTE;
      endcase
    end

    // ========================================================
    // bit handling
    if (q.ev && q.ph != ph_idle && q.ph != ph_ignore) begin
      if (q.cnt != BITS_PER_BYTE) begin
        d.sh = byte_in;
        d.cnt = q.cnt + 4'h1;
        if (q.cnt == BITS_PER_BYTE - 4'h1) begin
          d.ack = 1'b1;
          d.crc = pm_crc8(q.crc, (q.ph == ph_read) ? q.tx : byte_in);
          case (q.ph)
            ph_addr: begin
              d.ridx = 3'h0;
              d.ara = 1'b0;
              if (byte_in[7:1] == addr_s) begin
                d.ph = byte_in[0] ? ph_read : ph_cmd;
                d.tx = rd_c;
              end else if (byte_in[7:1] == ARA_ADDR && byte_in[0] && q.alert) begin
                d.ph = ph_read; // [R9]
                d.ara = 1'b1;
                d.tx = {addr_s, 1'b0}; // [R10]
              end else begin
                d.ph = ph_ignore; // [R9]
                d.ack = 1'b0;
              end
            end
            ph_cmd: begin
              d.cmd = byte_in;
              d.widx = 3'h0;
              d.ph = ph_data;
              d.bad = 1'b0;
              if (pm_wr_len(byte_in) == LEN_BAD && pm_rd_len(byte_in) == LEN_BAD) begin
                d.bad = 1'b1; // [R7]
                cml_set = 1'b1; // [R15]
              end
            end
            ph_data: begin
              // refuses read-only codes, unknown codes and excess bytes
              if (q.bad || wlen_c == LEN_BAD || q.widx > wlen_c) begin
                d.ack = 1'b0; // [R15] [R6]
                d.bad = 1'b1;
                cml_set = 1'b1;
              end else begin
                d.wbuf[2'(q.widx)] = byte_in;
                d.widx = q.widx + 3'h1;
                d.crc_prev = q.crc;
              end
            end
            ph_read: begin
              d.ack = 1'b0;
              if (q.ara && q.ridx == 3'h0) begin
                d.alert = 1'b0; // address handed over [R10]
              end
            end
            default: d.ack = 1'b0;
          endcase
        end
      end else begin
        // ninth clock: acknowledge slot
        d.cnt = 4'h0;
        // our own ack of the address staged the first byte already, so
        // only the master's ack after a data byte moves the read on
        if (q.ph == ph_read && !q.ack) begin
          if (bit_s) begin
            d.ph = ph_ignore;
          end else begin
            d.ridx = q.ridx + 3'h1;
            if (q.ara) begin
              d.tx = (q.ridx == 3'h0) ? q.crc : IDLE_BYTE; // [R4]
            end else begin
              d.tx = rd_c;
            end
          end
        end
      end
    end

    // only the data line is driven, on clock low; clock never held [R2]
    if (fall_c) begin
      d.oe = 1'b0;
      if (q.ph != ph_idle && q.ph != ph_ignore) begin
        if (q.cnt == BITS_PER_BYTE) begin
          d.oe = q.ack;
        end else if (q.ph == ph_read) begin
          d.oe = ~q.tx[3'(BITS_PER_BYTE - 4'h1 - q.cnt)];
        end
      end
    end

    // ========================================================
    // frame boundaries
    if (start_c) begin
      // a repeated start keeps the running check byte
      if (!q.busy) begin
        d.crc = CRC_INIT;
      end
      d.busy = 1'b1;
      d.ph = ph_addr;
      d.cnt = 4'h0;
      d.ack = 1'b0;
      d.oe = 1'b0;
    end

    if (stop_c) begin
      if (q.busy && q.ph == ph_data && !q.bad) begin
        // check byte only counts if the master clocked it [R4]
        if (q.widx == wlen_c) begin
          wr_ok = 1'b1;
        end else if (q.widx == wlen_c + 3'h1 && q.wbuf[2'(wlen_c)] == q.crc_prev) begin
          wr_ok = 1'b1; // [R4]
        end else begin
          cml_set = 1'b1; // [R15]
        end
      end
      d.busy = 1'b0;
      d.ph = ph_idle;
      d.oe = 1'b0;
    end

    // writes take effect only at stop, once the length is known
    if (wr_ok) begin
      case (q.cmd)
        CMD_CLEAR_FAULTS: begin
          d.cml = 1'b0;
          d.alert = 1'b0;
        end
        CMD_STORE_USER_ALL: d.nvm_pulse = 1'b1; // [R13] [R12]
        CMD_VOUT_COMMAND: d.vout = {q.wbuf[1], q.wbuf[0]}; // [R5]
        CMD_IOUT_OC_FAULT_LIMIT: begin
          if (q.wbuf[1][OC_EXP_HI:OC_EXP_LO] == OC_EXP) begin
            d.oclim = {q.wbuf[1], q.wbuf[0]};
          end else begin
            d.cml = 1'b1; // [R5]
          end
        end
        default: d.cml = 1'b1;
      endcase
    end

    // a fault raised in the cycle of a clear still stands
    if (cml_set) begin
      d.cml = 1'b1;
    end

    // ========================================================
    // clock-low timeout, counter saturates
    if (scl_s) begin
      d.low_cnt = '0;
    end else if (q.low_cnt != TMO) begin
      d.low_cnt = q.low_cnt + LOW_CNT_W'(1);
    end
    if (q.low_cnt == TMO && q.busy) begin
      d.busy = 1'b0; // [R14]
      d.ph = ph_idle;
      d.oe = 1'b0;
      // forget any half-received byte
      d.cnt = 4'h0;
      d.ack = 1'b0;
    end

    // ========================================================
    // alert: a new event wins over a clear in the same cycle
    d.fault_p = ext_fault;
    if ((d.cml && !q.cml) || (ext_fault && !q.fault_p)) begin
      d.alert = 1'b1; // [R8]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '0;
      q.ph <= ph_idle;
      q.crc <= CRC_INIT;
      q.vout <= VOUT_DEF;
      q.oclim <= OC_DEF;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  assign sda_out = 1'b0;
  assign sda_oe = q.oe;
  assign alert_request_line_out = 1'b0;
  assign alert_request_line_oe = q.alert; // [R8]
  assign vout_command = q.vout;
  assign oc_fault_limit = q.oclim;
  assign nvm_store_pulse = q.nvm_pulse; // [R12]
  assign comm_fault = q.cml;

endmodule

// ### dv/pm_slave_core_props.sv
`timescale 1ns/1ps
module pm_slave_core_props #(
  parameter int unsigned TIMEOUT_CYCLES = 200
) (
  input wire logic ref_clk, // core clock
  input wire logic rst, // sync reset
  input wire logic scl_in, // clock wire
  input wire logic sda_in, // data wire
  input wire logic sda_out, // data value
  input wire logic sda_oe, // data pull
  input wire logic alert_request_line_out, // alert value
  input wire logic alert_request_line_oe, // alert pull
  input wire logic [15:0] vout_command, // vout
  input wire logic [15:0] oc_fault_limit, // oc limit
  input wire logic nvm_store_pulse, // commit
  input wire logic comm_fault // fault flag
);
  logic [31:0] low_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // clock-low run length, raw wire
  always_ff @(posedge ref_clk) begin
    low_q <= scl_in ? 32'h0 : low_q + 32'h1;
  end
  a_sda_val_low: assert property (sda_out == 1'b0) else $error("sda value");
  a_alert_val_low: assert property (alert_request_line_out == 1'b0) else $error("alert val");
  a_oe_clock_low: assert property ($rose(sda_oe) |-> !scl_in) else $error("oe edge");
  a_timeout_free: assert property (low_q > TIMEOUT_CYCLES + 12 |-> !sda_oe)
    else $error("timeout");
  a_vout_at_stop: assert property (!$stable(vout_command) |-> scl_in && sda_in)
    else $error("vout commit");
  a_oc_exp_fixed: assert property (oc_fault_limit[15:11] == 5'h1f) else $error("oc exp");
  a_store_one: assert property (nvm_store_pulse |=> !nvm_store_pulse) else $error("store");
  a_fault_alert: assert property ($rose(comm_fault) |-> ##[0:4] alert_request_line_oe)
    else $error("fault alert");
endmodule
bind pm_slave_core pm_slave_core_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_props (
  .ref_clk(ref_clk),
  .rst(rst),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe(sda_oe),
  .alert_request_line_out(alert_request_line_out),
  .alert_request_line_oe(alert_request_line_oe),
  .vout_command(vout_command),
  .oc_fault_limit(oc_fault_limit),
  .nvm_store_pulse(nvm_store_pulse),
  .comm_fault(comm_fault)
);

// ### dv/pm_host_model.sv
`timescale 1ns/1ps
module pm_host_model (
  output logic scl, // clock, master only
  output logic sda_low, // pulls data low
  input wire logic sda // data wire
);
  // half period well above core sampling needs, inside 10..400 kHz;
  // the fraction keeps wire changes off the core clock's rising edge
  localparam real H = 1510.2;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic xfer(input bit b, output bit r);
    #(H / 2) sda_low = !b;
    #(H / 2) scl = 1'b1;
    r = sda;
    #(H) scl = 1'b0;
  endtask
  task automatic start();
    #(H / 2) sda_low = 1'b0;
    #(H / 2) scl = 1'b1;
    #(H) sda_low = 1'b1;
    #(H) scl = 1'b0;
  endtask
  task automatic stop();
    #(H / 2) sda_low = 1'b1;
    #(H / 2) scl = 1'b1;
    #(H) sda_low = 1'b0;
    #(H);
  endtask
  task automatic wr(input logic [7:0] d, output bit ak);
    bit a;
    for (int i = 7; i >= 0; i--) xfer(d[i], a);
    xfer(1'b1, a);
    ak = !a;
  endtask
  // acking the trailing byte is what asks for the check byte
  task automatic rd(input bit ak, output logic [7:0] d);
    bit a;
    for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
    xfer(!ak, a);
  endtask
endmodule

// ### dv/test_pmbus_slave_interface.sv
`timescale 1ns/1ps
module test_pmbus_slave_interface;
  import pm_pkg::*;
  localparam int unsigned TO = 200;
  logic ref_clk, rst, ext_fault, sda_oe, al_oe, nvp, cf, m_low, scl;
  logic [6:0] own;
  logic [15:0] vout, oc, r;
  logic [7:0] p;
  wire sda;
  int err_count = 0, num_checks = 0, n_store = 0;
  int seed = 32'h218a2507;
  int m_vout, m_oc;
  bit ak;
  assign sda = ~(m_low | sda_oe);
  pm_host_model hm (.scl(scl), .sda_low(m_low), .sda(sda));
  pm_slave_core #(.TIMEOUT_CYCLES(TO)) DUT (.ref_clk(ref_clk), .rst(rst), .bus_clk(scl),
    .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .alert_request_line_out(),
    .alert_request_line_oe(al_oe), .own_addr(own), .ext_fault(ext_fault),
    .vout_command(vout), .oc_fault_limit(oc), .nvm_store_pulse(nvp), .comm_fault(cf));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (nvp === 1'b1) n_store++;
  task automatic chk(input string nm, input int e, input logic [15:0] g);
    num_checks++;
    if (g !== 16'(e)) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, 16'(e), g);
    end
  endtask
  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] x;
    x = c ^ b;
    repeat (8) x = x[7] ? (x << 1) ^ 8'h07 : x << 1;
    return x;
  endfunction
  task automatic idle();
    hm.stop();
    repeat (12) @(posedge ref_clk);
  endtask
  // pm: 0 no check byte, 1 good, 2 corrupted
  task automatic send(input logic [7:0] c, input int n, input logic [15:0] d, input int pm,
                      output bit ak);
    logic [7:0] x;
    bit a;
    x = crc(crc(8'h00, {own, 1'b0}), c);
    hm.start();
    hm.wr({own, 1'b0}, a);
    hm.wr(c, ak);
    for (int i = 0; i < n; i++) begin
      hm.wr(d[8*i+:8], ak);
      x = crc(x, d[8*i+:8]);
    end
    if (pm > 0) hm.wr(pm == 1 ? x : ~x, a);
    idle();
  endtask
  task automatic get(input logic [7:0] c, input int n, input bit pe, output logic [15:0] d);
    logic [7:0] x, b;
    bit a;
    d = 16'h0;
    x = crc(crc(crc(8'h00, {own, 1'b0}), c), {own, 1'b1});
    hm.start();
    hm.wr({own, 1'b0}, a);
    hm.wr(c, a);
    hm.start();
    hm.wr({own, 1'b1}, a);
    for (int i = 0; i < n; i++) begin
      hm.rd(i < n - 1 || pe, b);
      d[8*i+:8] = b;
      x = crc(x, b);
    end
    if (pe) begin
      hm.rd(1'b0, b);
      chk("pec", x, b);
    end
    idle();
  endtask
  task automatic ara(output bit ak, output logic [7:0] b);
    b = 8'h0;
    hm.start();
    hm.wr({ARA_ADDR, 1'b1}, ak);
    if (ak) hm.rd(1'b0, b);
    idle();
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #3_000_000;
    err_count++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    ext_fault = 1'b0;
    own = 7'h40;
    @(posedge ref_clk);
    own <= {2'b10, 5'($random(seed))};
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (10) @(posedge ref_clk);
    m_vout = VOUT_DEF;
    m_oc = OC_DEF;
    chk("vout", m_vout, vout);
    chk("oc", m_oc, oc);
    $display("done reset");
    r = 16'($random(seed));
    send(CMD_VOUT_COMMAND, 2, r, 1, ak);
    m_vout = r;
    chk("vout_wr", m_vout, vout);
    get(CMD_VOUT_COMMAND, 2, 1'b1, r);
    chk("vout_rd", m_vout, r);
    send(CMD_VOUT_COMMAND, 2, ~r, 2, ak);
    chk("vout_bad", m_vout, vout);
    chk("cf_pec", 1, cf);
    $display("done words");
    get(CMD_VOUT_MODE, 1, 1'b0, r);
    chk("mode", VOUT_MODE_VAL, r);
    r = {OC_EXP, 11'($random(seed))};
    send(CMD_IOUT_OC_FAULT_LIMIT, 2, r, 0, ak);
    m_oc = r;
    chk("oc_wr", m_oc, oc);
    send(CMD_IOUT_OC_FAULT_LIMIT, 2, {5'h1e, r[10:0]}, 0, ak);
    chk("oc_exp", m_oc, oc);
    send(CMD_CLEAR_FAULTS, 0, 16'h0, 0, ak);
    chk("cf_clr", 0, cf);
    $display("done format");
    send(8'hab, 1, 16'h5a, 0, ak);
    chk("data_ack", 0, ak);
    chk("cf", 1, cf);
    chk("alert", 1, al_oe);
    ara(ak, p);
    chk("ara_ack", 1, ak);
    chk("ara_addr", {own, 1'b0}, p);
    chk("alert_off", 0, al_oe);
    ext_fault <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("alert_ext", 1, al_oe);
    get(CMD_STATUS_BYTE, 1, 1'b0, r);
    chk("status", 3, r);
    send(CMD_CLEAR_FAULTS, 0, 16'h0, 0, ak);
    ara(ak, p);
    chk("ara_none", 0, ak);
    ext_fault <= 1'b0;
    $display("done alert");
    chk("no_store", 0, n_store);
    send(CMD_STORE_USER_ALL, 0, 16'h0, 1, ak);
    chk("store", 1, n_store);
    send(CMD_STATUS_BYTE, 1, 16'h5a, 0, ak);
    chk("ro_ack", 0, ak);
    chk("ro_cf", 1, cf);
    send(CMD_VOUT_COMMAND, 1, r, 0, ak);
    chk("short_vout", m_vout, vout);
    $display("done store");
    hm.start();
    hm.wr({own, 1'b0}, ak);
    hm.wr(CMD_VOUT_MODE, ak);
    hm.start();
    hm.wr({own, 1'b1}, ak);
    repeat (20) @(posedge ref_clk);
    chk("oe_hold", 1, sda_oe);
    repeat (TO + 20) @(posedge ref_clk);
    chk("oe_free", 0, sda_oe);
    idle();
    $display("done timeout");
    conclude();
  end
endmodule
